// File: design/mprb_pkg.sv
// Constants and carrier types for the memory ports and refresh block.
// Assumes a 20 MHz system clock and byte-wide channel I/O data.
package mprb_pkg;

    // Register I/O addresses
    localparam logic [15:0] ADDR_ENC_LOW   = 16'h00E0;
    localparam logic [15:0] ADDR_ENC_HIGH  = 16'h00E1;
    localparam logic [15:0] ADDR_TRC_UPPER = 16'h00E3;
    localparam logic [15:0] ADDR_TRC_MID   = 16'h00E4;
    localparam logic [15:0] ADDR_TRC_LOWER = 16'h00E5;
    localparam logic [15:0] ADDR_TRC_KIND  = 16'h00E7;
    localparam logic [15:0] ADDR_SETUP     = 16'h0103;

    // Field positions
    localparam int MEM_EN_BIT      = 0;
    localparam int RATE_BIT        = 1;
    localparam int CARD_EN_HI_BIT  = 5;
    localparam int CARD_EN_LO_BIT  = 4;
    localparam int SPLIT_DIS_BIT   = 3;
    localparam int SPLIT_512_BIT   = 2;
    localparam int SHADOW_BIT      = 1;
    localparam int PARITY_DIS_BIT  = 0;

    // Reset values
    localparam logic [7:0] ENC_RST   = 8'hFF;
    localparam logic [7:0] TRC_RST   = 8'h00;
    localparam logic       MEM_EN_RST = 1'b1;
    localparam logic       RATE_RST   = 1'b1;

    // Refresh timing
    localparam int CLK_PERIOD_NS    = 50;
    localparam int REF_PULSE_NS     = 400;
    localparam int REF_SLOW_NS      = 15120;
    localparam int REF_FAST_NS      = 800;
    localparam int REF_PULSE_CYC    = REF_PULSE_NS / CLK_PERIOD_NS;
    localparam int REF_SLOW_CYC     = REF_SLOW_NS / CLK_PERIOD_NS;
    localparam int REF_FAST_CYC     = REF_FAST_NS / CLK_PERIOD_NS;
    localparam int REF_CNT_W        = 9;

    // Fixed split in personality A, and sixteen megabytes in 1 MB units
    localparam logic [3:0] FULL_MB_TOP = 4'hF;

    typedef enum logic [3:0] {
        PERS_A = 4'b0001,
        PERS_B = 4'b0010,
        PERS_C = 4'b0100,
        PERS_D = 4'b1000
    } personality_t;

    // Channel I/O request
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } io_req_t;

    // Byte answer on the data bus
    typedef struct packed {
        logic [7:0] data;
        logic [7:0] oe;
    } io_rsp_t;

    // Captured bus cycle
    typedef struct packed {
        logic [23:2] addr;
        logic        mem_io;
        logic        data_ctl;
        logic        arbitration_grant_flag;
    } trace_t;

    // Memory map controls seen by the DRAM and ROM decode
    typedef struct packed {
        logic       dram_enable;
        logic [3:0] mb_enable;
        logic       split_disable;
        logic       split_512;
        logic       low_rom_enable;
        logic       high_rom_enable;
        logic       parity_enable;
        logic [3:0] remap_base;
    } map_ctl_t;

endpackage

// File: design/memory_ports_refresh_block.sv
// Ports and registers of the address bus controller: setup port, encoding
// registers, error trace, refresh timer and memory map controls.
// Assumes channel I/O strobes are one-cycle pulses synchronous to ref_clk_i.
//
// Overview of operation
// R1: Two straps select personality A, B, C or D.
// R2: Personality A hides encoding and trace registers; only setup port exists.
// R3: In A and D setup port bit 0 is memory enable, read/write, resets 1.
// R4: Reading setup port in A and D drives only data bit 0.
// R5: Memory enable 0 disables all DRAM access but refresh continues.
// R6: In A and D refresh gives 400 ns pulse every 15.12 us; code period is 302 cycles, 15.1 us.
// R7: Personality A fixes the first-megabyte split at 640 KB.
// R8: In A, 384 KB beyond split disabled at 16 MB, else remapped past DRAM.
// R9: In A, BIOS ROM decoded at low and high ranges.
// R10: In B and C setup port bit 0 is absent.
// R11: In B and C setup port bit 1 is write-only rate bit, resets 1.
// R12: Rate bit 0 gives continuous 400 ns pulses every 800 ns.
// R13: Setup port answers only while the board is in setup mode.
// R14: In B card-enable bits gate first four DRAM megabytes.
// R15: In C and D card-enable bits are plain storage.
// R16: In D mapping follows encoding registers; setup port as in A.
// R17: In B, C, D four read-only trace registers are readable.
// R18: Each strobe rising edge captures address, memory/IO, data/control, grant.
// R19: Refresh requests go out; own refresh address drives the DRAMs.
// R20: Trace registers reset to 00; fourth drives only data bit 0.
// R21: Capture strobe is synchronised before its edge is used.
`timescale 1ns/1ps

module memory_ports_refresh_block #(
    parameter int REF_ADDR_W = 11
) (
    // Clock and reset
    input  wire logic                     ref_clk_i,
    input  wire logic                     nrst_i,
    // Straps and board state
    input  wire logic                     personality_strap_a_i,
    input  wire logic                     personality_strap_b_i,
    input  wire logic                     setup_mode_i,
    input  wire logic [3:0]               dram_top_mb_i,
    // Channel I/O
    input  wire mprb_pkg::io_req_t        io_req_i,
    output logic      [7:0]               io_rdata_o,
    output logic      [7:0]               io_oe_o,
    // Error capture
    input  wire logic                     error_capture_strobe_i,
    input  wire logic [23:2]              system_address_bits_i,
    input  wire logic                     mem_io_i,
    input  wire logic                     data_ctl_i,
    input  wire logic                     arbitration_grant_flag_i,
    // Refresh and memory control
    input  wire logic                     refresh_ack_i,
    output logic                          refresh_req_o,
    output logic      [REF_ADDR_W-1:0]    refresh_addr_o,
    output mprb_pkg::map_ctl_t            map_ctl_o
);

    // Personality decode, registered from the straps on every clock after reset
    mprb_pkg::personality_t pers_ff, nxt_pers;

    always_comb begin
        unique case ({personality_strap_b_i, personality_strap_a_i})  // [R1]
            2'b00:   nxt_pers = mprb_pkg::PERS_A;
            2'b01:   nxt_pers = mprb_pkg::PERS_B;
            2'b11:   nxt_pers = mprb_pkg::PERS_C;
            2'b10:   nxt_pers = mprb_pkg::PERS_D;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pers_ff <= mprb_pkg::PERS_A;
        end else begin
            pers_ff <= nxt_pers;
        end
    end

    logic is_a, is_b, is_c, is_d, has_e_regs, port_a_style;
    assign is_a         = (pers_ff == mprb_pkg::PERS_A);
    assign is_b         = (pers_ff == mprb_pkg::PERS_B);
    assign is_c         = (pers_ff == mprb_pkg::PERS_C);
    assign is_d         = (pers_ff == mprb_pkg::PERS_D);
    assign has_e_regs   = !is_a;                       // [R2] [R17]
    assign port_a_style = is_a || is_d;                // [R16]

    // Strobe synchroniser; first stage only feeds the second
    logic ers_s1_ff, ers_s2_ff, ers_s3_ff;
    logic ers_rise;

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ers_s1_ff <= 1'b0;
            ers_s2_ff <= 1'b0;
            ers_s3_ff <= 1'b0;
        end else begin
            ers_s1_ff <= error_capture_strobe_i;
            ers_s2_ff <= ers_s1_ff;
            ers_s3_ff <= ers_s2_ff;
        end
    end

    assign ers_rise = ers_s2_ff && !ers_s3_ff;         // [R21]

    // Register state
    logic [7:0]        enc_lo_ff, nxt_enc_lo;
    logic [7:0]        enc_hi_ff, nxt_enc_hi;
    logic              mem_en_ff, nxt_mem_en;
    logic              rate_ff, nxt_rate;
    mprb_pkg::trace_t  trc_ff, nxt_trc;
    logic              wr_setup;

    // Setup port is decoded only while the board is in setup mode
    assign wr_setup = io_req_i.wr && setup_mode_i
                      && (io_req_i.addr == mprb_pkg::ADDR_SETUP);  // [R13]

    always_comb begin
        nxt_enc_lo = enc_lo_ff;
        nxt_enc_hi = enc_hi_ff;
        nxt_mem_en = mem_en_ff;
        nxt_rate   = rate_ff;
        nxt_trc    = trc_ff;
        if (wr_setup && port_a_style) begin
            nxt_mem_en = io_req_i.wdata[mprb_pkg::MEM_EN_BIT];   // [R3]
        end
        if (wr_setup && (is_b || is_c)) begin
            nxt_rate = io_req_i.wdata[mprb_pkg::RATE_BIT];       // [R11] [R10]
        end
        if (io_req_i.wr && has_e_regs && io_req_i.addr == mprb_pkg::ADDR_ENC_LOW) begin
            nxt_enc_lo = io_req_i.wdata;                          // [R15]
        end
        if (io_req_i.wr && has_e_regs && io_req_i.addr == mprb_pkg::ADDR_ENC_HIGH) begin
            nxt_enc_hi = io_req_i.wdata;
        end
        if (ers_rise) begin
            nxt_trc.addr     = system_address_bits_i;             // [R18]
            nxt_trc.mem_io   = mem_io_i;
            nxt_trc.data_ctl = data_ctl_i;
            nxt_trc.arbitration_grant_flag  = arbitration_grant_flag_i;
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            enc_lo_ff <= mprb_pkg::ENC_RST;
            enc_hi_ff <= mprb_pkg::ENC_RST;
            mem_en_ff <= mprb_pkg::MEM_EN_RST;                    // [R3]
            rate_ff   <= mprb_pkg::RATE_RST;                      // [R11]
            trc_ff    <= '0;                                      // [R20]
        end else begin
            enc_lo_ff <= nxt_enc_lo;
            enc_hi_ff <= nxt_enc_hi;
            mem_en_ff <= nxt_mem_en;
            rate_ff   <= nxt_rate;
            trc_ff    <= nxt_trc;
        end
    end

    // Read path: one registered cycle after the read strobe
    logic [7:0] rdata_ff, nxt_rdata;
    logic [7:0] oe_ff, nxt_oe;

    always_comb begin
        nxt_rdata = 8'h00;
        nxt_oe    = 8'h00;
        if (io_req_i.rd) begin
            unique case (io_req_i.addr)
                mprb_pkg::ADDR_SETUP: begin
                    // Rate bit is write-only, so B and C never drive the bus
                    if (setup_mode_i && port_a_style) begin          // [R13]
                        nxt_rdata = {7'h00, mem_en_ff};              // [R4]
                        nxt_oe    = 8'h01;
                    end
                end
                mprb_pkg::ADDR_ENC_LOW: begin
                    if (has_e_regs) begin                            // [R2]
                        nxt_rdata = enc_lo_ff;
                        nxt_oe    = 8'hFF;
                    end
                end
                mprb_pkg::ADDR_ENC_HIGH: begin
                    if (has_e_regs) begin
                        nxt_rdata = enc_hi_ff;
                        nxt_oe    = 8'hFF;
                    end
                end
                mprb_pkg::ADDR_TRC_UPPER: begin
                    if (has_e_regs) begin                            // [R17]
                        nxt_rdata = trc_ff.addr[23:16];
                        nxt_oe    = 8'hFF;
                    end
                end
                mprb_pkg::ADDR_TRC_MID: begin
                    if (has_e_regs) begin
                        nxt_rdata = trc_ff.addr[15:8];
                        nxt_oe    = 8'hFF;
                    end
                end
                mprb_pkg::ADDR_TRC_LOWER: begin
                    if (has_e_regs) begin
                        nxt_rdata = {trc_ff.addr[7:2], trc_ff.mem_io, trc_ff.arbitration_grant_flag};
                        nxt_oe    = 8'hFF;
                    end
                end
                mprb_pkg::ADDR_TRC_KIND: begin
                    if (has_e_regs) begin
                        nxt_rdata = {7'h00, trc_ff.data_ctl};        // [R20]
                        nxt_oe    = 8'h01;
                    end
                end
                default: begin
                    nxt_rdata = 8'h00;
                    nxt_oe    = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_ff <= 8'h00;
            oe_ff    <= 8'h00;
        end else begin
            rdata_ff <= nxt_rdata;
            oe_ff    <= nxt_oe;
        end
    end

    assign io_rdata_o = rdata_ff;
    assign io_oe_o    = oe_ff;

    // Refresh timer: period restarts at each pulse start
    logic [mprb_pkg::REF_CNT_W-1:0] ref_cnt_ff, nxt_ref_cnt;
    logic [mprb_pkg::REF_CNT_W-1:0] ref_last;
    logic                           req_ff, nxt_req;
    logic [REF_ADDR_W-1:0]          raddr_ff, nxt_raddr;
    logic                           slow_rate;

    assign slow_rate = port_a_style || rate_ff;                    // [R6] [R11]
    assign ref_last  = slow_rate
        ? mprb_pkg::REF_CNT_W'(mprb_pkg::REF_SLOW_CYC - 1)
        : mprb_pkg::REF_CNT_W'(mprb_pkg::REF_FAST_CYC - 1);        // [R12]

    always_comb begin
        nxt_ref_cnt = (ref_cnt_ff >= ref_last) ? '0 : ref_cnt_ff + 1'b1;
        nxt_req     = (nxt_ref_cnt < mprb_pkg::REF_CNT_W'(mprb_pkg::REF_PULSE_CYC));
        nxt_raddr   = raddr_ff;
        // Own refresh row advances once per pulse; DMA address is not used
        if (refresh_ack_i && req_ff && !nxt_req) begin
            nxt_raddr = raddr_ff + 1'b1;                           // [R19]
        end else if (!refresh_ack_i && req_ff && !nxt_req) begin
            nxt_raddr = raddr_ff + 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            // Start at the wrap point so the first pulse after reset is full length
            ref_cnt_ff <= '1;                                      // [R6]
            req_ff     <= 1'b0;
            raddr_ff   <= '0;
        end else begin
            ref_cnt_ff <= nxt_ref_cnt;
            req_ff     <= nxt_req;
            raddr_ff   <= nxt_raddr;
        end
    end

    assign refresh_req_o  = req_ff;                                // [R19]
    assign refresh_addr_o = raddr_ff;

    // Memory map controls, registered
    mprb_pkg::map_ctl_t map_ff, nxt_map;

    always_comb begin
        nxt_map = '0;
        if (is_a) begin
            nxt_map.dram_enable     = mem_en_ff;                   // [R5]
            nxt_map.mb_enable       = 4'hF;
            nxt_map.split_512       = 1'b0;                        // [R7]
            nxt_map.split_disable   = (dram_top_mb_i == mprb_pkg::FULL_MB_TOP);  // [R8]
            nxt_map.remap_base      = dram_top_mb_i + 4'h1;
            nxt_map.low_rom_enable  = 1'b1;                        // [R9]
            nxt_map.high_rom_enable = 1'b1;
            nxt_map.parity_enable   = 1'b1;
        end else begin
            nxt_map.dram_enable     = is_d ? mem_en_ff : 1'b1;     // [R5] [R16]
            nxt_map.mb_enable       = is_b
                ? ~{enc_lo_ff[mprb_pkg::CARD_EN_HI_BIT], enc_lo_ff[mprb_pkg::CARD_EN_LO_BIT],
                    enc_hi_ff[mprb_pkg::CARD_EN_HI_BIT], enc_hi_ff[mprb_pkg::CARD_EN_LO_BIT]}
                : 4'hF;                                            // [R14] [R15]
            nxt_map.split_disable   = enc_hi_ff[mprb_pkg::SPLIT_DIS_BIT];
            nxt_map.split_512       = enc_hi_ff[mprb_pkg::SPLIT_512_BIT];
            nxt_map.remap_base      = enc_lo_ff[3:0];
            nxt_map.low_rom_enable  = enc_hi_ff[mprb_pkg::SHADOW_BIT]
                                      || (is_d && !mem_en_ff);
            nxt_map.high_rom_enable = 1'b1;
            nxt_map.parity_enable   = !enc_hi_ff[mprb_pkg::PARITY_DIS_BIT];
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            map_ff <= '0;
        end else begin
            map_ff <= nxt_map;
        end
    end

    assign map_ctl_o = map_ff;

    // Checks
    sequence ers_edge_s;
        ers_s2_ff && !ers_s3_ff;
    endsequence

    trace_capture_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)  // [R18]
        ers_edge_s |=> (trc_ff.addr == $past(system_address_bits_i)))
        else $error("trace did not capture address");
    setup_gate_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)  // [R13]
        (io_req_i.rd && !setup_mode_i && io_req_i.addr == mprb_pkg::ADDR_SETUP)
        |=> (oe_ff == 8'h00))
        else $error("setup port answered outside setup mode");
    setup_read_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)  // [R4]
        (io_req_i.rd && setup_mode_i && port_a_style && io_req_i.addr == mprb_pkg::ADDR_SETUP)
        |=> (oe_ff == 8'h01 && rdata_ff[0] == $past(mem_en_ff)))
        else $error("setup port read wrong");
    hide_regs_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)  // [R2]
        (io_req_i.rd && is_a && io_req_i.addr != mprb_pkg::ADDR_SETUP) |=> (oe_ff == 8'h00))
        else $error("register visible in personality A");
    kind_read_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)  // [R20]
        (io_req_i.rd && has_e_regs && io_req_i.addr == mprb_pkg::ADDR_TRC_KIND)
        |=> (oe_ff == 8'h01))
        else $error("fourth trace register drove upper bits");
    pulse_len_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)  // [R6]
        $rose(req_ff) |-> req_ff[*8] ##1 !req_ff)
        else $error("refresh pulse not 400 ns");
    fast_rate_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)  // [R12]
        ($fell(req_ff) && !slow_rate && $stable(slow_rate)) |-> !req_ff[*8] ##1 req_ff)
        else $error("fast refresh period not 800 ns");
    mem_off_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)  // [R5]
        (is_a && !mem_en_ff) |=> !map_ff.dram_enable)
        else $error("DRAM enabled with memory enable clear");
    card_gate_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)  // [R15]
        (is_c || is_d) |=> (map_ff.mb_enable == 4'hF))
        else $error("card bits gated memory in C or D");

endmodule

// File: verif/io_master_model.sv
// Channel I/O master and DMA refresh acknowledger facing the block.
// Assumes the block's clock; every request launches 1 ns after a rising edge.
`timescale 1ns/1ps

module io_master_model (
    // Clock
    input  wire logic               clk_i,
    // Channel side
    output mprb_pkg::io_req_t       io_req_o,
    input  wire logic [7:0]         io_rdata_i,
    input  wire logic [7:0]         io_oe_i,
    // Refresh handshake
    input  wire logic               refresh_req_i,
    output logic                    refresh_ack_o
);
    initial begin
        io_req_o      = '0;
        refresh_ack_o = 1'b0;
    end

    // Released address and data lines show the inverse of the last value, so a stale copy never passes
    task automatic drive(input logic rd, input logic wr, input logic [15:0] a,
                         input logic [7:0] d);
        @(posedge clk_i);
        #1;
        io_req_o = '{rd: rd, wr: wr, addr: a, wdata: d};
        @(posedge clk_i);
        #1;
        io_req_o = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    endtask

    task automatic io_write(input logic [15:0] a, input logic [7:0] d);
        drive(1'b0, 1'b1, a, d);
    endtask

    task automatic io_read(input logic [15:0] a, output logic [7:0] d, output logic [7:0] oe);
        drive(1'b1, 1'b0, a, 8'h00);
        d  = io_rdata_i;
        oe = io_oe_i;
    endtask

    // The DMA side answers one cycle late; the block must not depend on it
    always @(posedge clk_i) begin
        refresh_ack_o <= #1 refresh_req_i;
    end
endmodule

// File: verif/memory_ports_refresh_block_tb_top.sv
// Self-checking bench for the memory ports and refresh block, all four personalities.
// Assumes io_master_model as the channel master and DMA acknowledger.
`timescale 1ns/1ps

module memory_ports_refresh_block_tb_top;
    localparam int PER_NS = 50;

    logic               clk;
    logic               nrst_i;
    logic               strap_a;
    logic               strap_b;
    logic               setup_mode;
    logic [3:0]         dram_top;
    mprb_pkg::io_req_t  io_req;
    logic [7:0]         rdata;
    logic [7:0]         oe;
    logic               strobe;
    logic [23:2]        sa;
    logic               mem_io;
    logic               data_ctl;
    logic               arbitration_grant_flag;
    logic               ack;
    logic               req;
    logic [10:0]        row;
    logic [10:0]        r0;
    mprb_pkg::map_ctl_t map_ctl;
    int                 err_total;
    int                 cmp_count;
    int                 hi;
    int                 per;

    memory_ports_refresh_block dut (
        .ref_clk_i                (clk),
        .nrst_i                   (nrst_i),
        .personality_strap_a_i    (strap_a),
        .personality_strap_b_i    (strap_b),
        .setup_mode_i             (setup_mode),
        .dram_top_mb_i            (dram_top),
        .io_req_i                 (io_req),
        .io_rdata_o               (rdata),
        .io_oe_o                  (oe),
        .error_capture_strobe_i   (strobe),
        .system_address_bits_i    (sa),
        .mem_io_i                 (mem_io),
        .data_ctl_i               (data_ctl),
        .arbitration_grant_flag_i (arbitration_grant_flag),
        .refresh_ack_i            (ack),
        .refresh_req_o            (req),
        .refresh_addr_o           (row),
        .map_ctl_o                (map_ctl)
    );

    io_master_model u_host (
        .clk_i         (clk),
        .io_req_o      (io_req),
        .io_rdata_i    (rdata),
        .io_oe_i       (oe),
        .refresh_req_i (req),
        .refresh_ack_o (ack)
    );

    initial begin
        clk = 1'b0;
        forever #(PER_NS / 2) clk = ~clk;
    end

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    task automatic chk_cnt(input int got, input int exp);
        cmp_count++;
        if (got != exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    // Undriven data bits carry no meaning, so only enabled bits are compared
    task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp_d, input logic [7:0] exp_oe);
        logic [7:0] d;
        logic [7:0] e;
        u_host.io_read(a, d, e);
        chk_byte(e, exp_oe);
        chk_byte(d & exp_oe, exp_d);
    endtask

    task automatic do_reset(input logic a, input logic b);
        nrst_i  = 1'b0;
        strap_a = a;
        strap_b = b;
        repeat (10) @(posedge clk);
        #1;
        nrst_i = 1'b1;
        repeat (2) @(posedge clk);
        #1;
    endtask

    // Aligns on a fresh rising edge of the refresh pulse, then times one full period
    task automatic measure(output int h, output int p, output logic [10:0] r);
        int n;
        n = 0;
        while (req === 1'b1 && n < 1000) begin @(posedge clk); #1; n++; end
        while (req !== 1'b1 && n < 1000) begin @(posedge clk); #1; n++; end
        r = row;
        h = 0;
        p = 0;
        while (req === 1'b1 && p < 1000) begin @(posedge clk); #1; h++; p++; end
        while (req !== 1'b1 && p < 1000) begin @(posedge clk); #1; p++; end
    endtask

    task automatic complete_run;
        $display("Summary: %0d mismatches in %0d comparisons", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        #(20000 * PER_NS);
        err_total++;
        complete_run();
    end

    initial begin
        err_total  = 0;
        cmp_count  = 0;
        nrst_i     = 1'b0;
        strap_a    = 1'b0;
        strap_b    = 1'b0;
        setup_mode = 1'b1;
        dram_top   = 4'h3;
        strobe     = 1'b0;
        sa         = '0;
        mem_io     = 1'b0;
        data_ctl   = 1'b0;
        arbitration_grant_flag    = 1'b0;
        // Personality A, 4 MB fitted
        do_reset(1'b0, 1'b0);
        rd_chk(mprb_pkg::ADDR_SETUP, 8'h01, 8'h01);
        rd_chk(mprb_pkg::ADDR_ENC_LOW, 8'h00, 8'h00);
        rd_chk(mprb_pkg::ADDR_TRC_UPPER, 8'h00, 8'h00);
        chk_byte({4'h0, map_ctl.remap_base}, 8'h04);
        chk_byte({6'h0, map_ctl.low_rom_enable, map_ctl.high_rom_enable}, 8'h03);
        chk_byte({7'h0, map_ctl.split_512}, 8'h00);
        u_host.io_write(mprb_pkg::ADDR_SETUP, 8'hFE);
        rd_chk(mprb_pkg::ADDR_SETUP, 8'h00, 8'h01);
        chk_byte({7'h0, map_ctl.dram_enable}, 8'h00);
        measure(hi, per, r0);
        chk_cnt(hi, mprb_pkg::REF_PULSE_CYC);
        chk_cnt(per, mprb_pkg::REF_SLOW_CYC);
        chk_byte(8'(row - r0), 8'h01);
        // Host leaves setup mode: the port must ignore both directions
        setup_mode = 1'b0;
        rd_chk(mprb_pkg::ADDR_SETUP, 8'h00, 8'h00);
        u_host.io_write(mprb_pkg::ADDR_SETUP, 8'hFF);
        setup_mode = 1'b1;
        rd_chk(mprb_pkg::ADDR_SETUP, 8'h00, 8'h01);
        dram_top = 4'hF;
        repeat (2) @(posedge clk);
        #1;
        chk_byte({7'h0, map_ctl.split_disable}, 8'h01);
        // Personality B
        do_reset(1'b1, 1'b0);
        rd_chk(mprb_pkg::ADDR_SETUP, 8'h00, 8'h00);
        rd_chk(mprb_pkg::ADDR_ENC_LOW, mprb_pkg::ENC_RST, 8'hFF);
        rd_chk(mprb_pkg::ADDR_TRC_KIND, 8'h00, 8'h01);
        chk_byte({4'h0, map_ctl.mb_enable}, 8'h00);
        u_host.io_write(mprb_pkg::ADDR_ENC_LOW, 8'hDF);
        u_host.io_write(mprb_pkg::ADDR_ENC_HIGH, 8'hEF);
        @(posedge clk);
        #1;
        chk_byte({4'h0, map_ctl.mb_enable}, 8'h09);
        sa       = 22'(24'hC3A55C >> 2);
        mem_io   = 1'b1;
        data_ctl = 1'b1;
        strobe   = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        // Inputs move after the capture; a falling strobe must not reload
        strobe = 1'b0;
        sa     = ~sa;
        mem_io = 1'b0;
        rd_chk(mprb_pkg::ADDR_TRC_UPPER, 8'hC3, 8'hFF);
        rd_chk(mprb_pkg::ADDR_TRC_MID, 8'hA5, 8'hFF);
        rd_chk(mprb_pkg::ADDR_TRC_LOWER, 8'h5E, 8'hFF);
        rd_chk(mprb_pkg::ADDR_TRC_KIND, 8'h01, 8'h01);
        u_host.io_write(mprb_pkg::ADDR_TRC_UPPER, 8'h00);
        rd_chk(mprb_pkg::ADDR_TRC_UPPER, 8'hC3, 8'hFF);
        measure(hi, per, r0);
        chk_cnt(per, mprb_pkg::REF_SLOW_CYC);
        u_host.io_write(mprb_pkg::ADDR_SETUP, 8'hFD);
        rd_chk(mprb_pkg::ADDR_SETUP, 8'h00, 8'h00);
        measure(hi, per, r0);
        chk_cnt(hi, mprb_pkg::REF_PULSE_CYC);
        chk_cnt(per, mprb_pkg::REF_FAST_CYC);
        // Personality C
        do_reset(1'b1, 1'b1);
        u_host.io_write(mprb_pkg::ADDR_ENC_HIGH, 8'h0F);
        rd_chk(mprb_pkg::ADDR_ENC_HIGH, 8'h0F, 8'hFF);
        chk_byte({4'h0, map_ctl.mb_enable}, 8'h0F);
        u_host.io_write(mprb_pkg::ADDR_SETUP, 8'hFD);
        measure(hi, per, r0);
        chk_cnt(per, mprb_pkg::REF_FAST_CYC);
        // Personality D: rate bit has no meaning, memory enable does
        do_reset(1'b0, 1'b1);
        rd_chk(mprb_pkg::ADDR_SETUP, 8'h01, 8'h01);
        rd_chk(mprb_pkg::ADDR_TRC_MID, 8'h00, 8'hFF);
        u_host.io_write(mprb_pkg::ADDR_SETUP, 8'hFC);
        rd_chk(mprb_pkg::ADDR_SETUP, 8'h00, 8'h01);
        chk_byte({7'h0, map_ctl.dram_enable}, 8'h00);
        chk_byte({4'h0, map_ctl.split_disable, map_ctl.split_512,
                  map_ctl.low_rom_enable, map_ctl.parity_enable}, 8'h0E);
        measure(hi, per, r0);
        chk_cnt(per, mprb_pkg::REF_SLOW_CYC);
        complete_run();
    end
endmodule
